/* core/pos_serial_pkg.sv */
package pos_serial_pkg;

    // link timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned BAUD_BPS        = 9_600;
    // bit period rounded down: 2604 cycles, 0.006 percent fast, well inside tolerance
    localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_BPS;
    localparam int unsigned BIT_CNT_W       = 12;

    // character layout
    localparam int unsigned CHARS_PER_VALUE = 8;
    localparam int unsigned NIBBLE_W        = 4;
    localparam int unsigned VALUE_W         = CHARS_PER_VALUE * NIBBLE_W;
    localparam int unsigned DATA_LSB        = 0;
    localparam int unsigned SEQ_LSB         = 4;
    localparam int unsigned FRAME_BITS      = 11;
    localparam logic [3:0]  SEQ_FIRST       = 4'h1;
    localparam logic        LINE_IDLE       = 1'b1;

    // reset values
    localparam logic [VALUE_W-1:0] VALUE_RST = 32'h0000_0000;

    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } enc_phase_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } diff_pair_t;

    typedef struct packed {
        diff_pair_t a;
        diff_pair_t b;
        diff_pair_t z;
    } enc_diff_t;

endpackage : pos_serial_pkg

/* core/char_serializer.sv */
`timescale 1ns/1ns
`default_nettype none

module char_serializer
    import pos_serial_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // character in
    input  wire logic       load_i,
    input  wire logic [7:0] char_i,
    output logic            busy_o,
    output logic            done_o,
    // serial line
    output logic            txd_o
);

    logic [FRAME_BITS-1:0] shift_q;
    logic [BIT_CNT_W-1:0]  tick_q;
    logic [3:0]            left_q;

    ////////////////////////////////////////////////////////////////////////
    // shifter: stop, even parity, data lsb first, start
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shift_q <= '1;
            tick_q  <= '0;
            left_q  <= '0;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            txd_o   <= LINE_IDLE;
        end
        else
        begin
            done_o <= 1'b0;
            if (!busy_o && load_i)
            begin
                // parity is xor of data so total ones even
                shift_q <= {1'b1, ^char_i, char_i, 1'b0};
                left_q  <= 4'(FRAME_BITS);
                tick_q  <= '0;
                busy_o  <= 1'b1;
                txd_o   <= 1'b0;
            end
            else if (busy_o)
            begin
                if (tick_q == BIT_CNT_W'(BIT_CYCLES - 1))
                begin
                    tick_q  <= '0;
                    shift_q <= {1'b1, shift_q[FRAME_BITS-1:1]};
                    left_q  <= left_q - 4'd1;
                    txd_o   <= (left_q == 4'd1) ? LINE_IDLE : shift_q[1];
                    if (left_q == 4'd1)
                    begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                end
                else
                begin
                    tick_q <= tick_q + 1'b1;
                end
            end
        end
    end

endmodule : char_serializer

`default_nettype wire

/* core/position_nibble_serial_out.sv */
// Overview of operation
// - counter value is split into eight characters sent back to back
// - each character: start, eight data bits lsb first, even parity, stop, 9600 bps
// - bits 0 to 3 of each character hold one value nibble
// - bits 4 to 7 hold the sequence number naming the nibble position
// - encoder phases a, b, z are driven out as differential pairs
`timescale 1ns/1ns
`default_nettype none

module position_nibble_serial_out
    import pos_serial_pkg::*;
(
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_b_i,
    // command counter
    input  wire logic [pos_serial_pkg::VALUE_W-1:0] value_i,
    input  wire logic                          send_i,
    output logic                               busy_o,
    output logic                               done_o,
    // serial current value line
    output logic                               txd_o,
    // encoder monitor
    input  wire pos_serial_pkg::enc_phase_t    enc_i,
    output pos_serial_pkg::enc_diff_t          enc_o
);
    import pos_serial_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE,
        S_LOAD,
        S_WAIT
    } state_t;

    state_t             state_q;
    logic [VALUE_W-1:0] value_q;
    logic [3:0]         seq_q;
    logic [7:0]         char_d;
    logic               load_q;
    logic               ser_busy;
    logic               ser_done;
    logic               ser_txd;
    logic               take;
    logic               char_end;
    logic               last_char;

    ////////////////////////////////////////////////////////////////////////
    // character build: low nibble data, high nibble sequence number
    always_comb
    begin
        char_d                             = '0;
        char_d[DATA_LSB +: NIBBLE_W]       = value_q[NIBBLE_W-1:0];
        char_d[SEQ_LSB +: NIBBLE_W]        = seq_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // request taken only from idle; a character ends on the serializer's done pulse
    // a request while busy is dropped here, never queued
    assign take      = (state_q == S_IDLE) && send_i;
    assign char_end  = (state_q == S_WAIT) && ser_done;
    assign last_char = (seq_q == 4'(CHARS_PER_VALUE));

    ////////////////////////////////////////////////////////////////////////
    // sequencer: idle, hand one character over, wait for its stop bit
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= S_IDLE;
        end
        else
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    if (take)
                    begin
                        state_q <= S_LOAD;
                    end
                end
                S_LOAD:
                begin
                    state_q <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (char_end)
                    begin
                        // eight characters per value, then back to idle
                        state_q <= last_char ? S_IDLE : S_LOAD;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // value latched once per request so a moving counter cannot tear a transfer
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            value_q <= VALUE_RST;
        end
        else if (take)
        begin
            value_q <= value_i;
        end
        else if (char_end && !last_char)
        begin
            // next more significant nibble moves down into the low bits
            value_q <= value_q >> NIBBLE_W;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequence number tells the host which nibble this character holds
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            seq_q <= SEQ_FIRST;
        end
        else if (take)
        begin
            seq_q <= SEQ_FIRST;
        end
        else if (char_end && !last_char)
        begin
            // one higher for each more significant nibble
            seq_q <= seq_q + 4'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle load strobe; the serializer ignores it while still busy
    // built from state so a stale strobe can never start a ninth character
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            load_q <= 1'b0;
        end
        else
        begin
            load_q <= (state_q == S_LOAD);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy flag for the requester
    // stays high from the cycle after taking until done
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_o <= 1'b0;
        end
        else if (take)
        begin
            busy_o <= 1'b1;
        end
        else if (char_end && last_char)
        begin
            busy_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // done pulse after the stop bit of the eighth character
    // one cycle only, so a level-held request restarts cleanly
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= char_end && last_char;
        end
    end

    char_serializer u_ser (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  (load_q),
        .char_i  (char_d),
        .busy_o  (ser_busy),
        .done_o  (ser_done),
        .txd_o   (ser_txd)
    );

    ////////////////////////////////////////////////////////////////////////
    // line output retimed; one cycle later than the serializer, harmless at 9600
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            txd_o <= LINE_IDLE;
        else
            txd_o <= ser_txd;
    end

    ////////////////////////////////////////////////////////////////////////
    // encoder phases to differential pairs, registered for clean outputs
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            enc_o <= '{a: '{1'b0, 1'b1}, b: '{1'b0, 1'b1}, z: '{1'b0, 1'b1}};
        else
        begin
            enc_o.a <= '{enc_i.a, ~enc_i.a};
            enc_o.b <= '{enc_i.b, ~enc_i.b};
            enc_o.z <= '{enc_i.z, ~enc_i.z};
        end
    end

endmodule : position_nibble_serial_out

`default_nettype wire

/* verif/pos_serial_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module pos_serial_monitor
    import pos_serial_pkg::*;
(
    // watched ports
    input wire logic               clk_i,
    input wire logic               rst_b_i,
    input wire logic [VALUE_W-1:0] value_i,
    input wire logic               send_i,
    input wire logic               busy_o,
    input wire logic               done_o,
    input wire logic               txd_o,
    input wire enc_phase_t         enc_i,
    input wire enc_diff_t          enc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [31:0] run_q;
    // cycles spent at the current line level
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            run_q <= 32'h0000_0001;
        else
            run_q <= (txd_o != $past(txd_o)) ? 32'h0000_0001 : run_q + 1;
    AST_IDLE_HIGH: assert property (!busy_o |-> txd_o)
        else $error("line not idle high");
    AST_START_LAT: assert property (send_i && !busy_o |-> ##4 !txd_o)
        else $error("start bit late");
    AST_LOW_RUN: assert property ($rose(txd_o) |-> run_q % 2604 == 0)
        else $error("low run not whole bits");
    AST_BUSY_END: assert property ($fell(busy_o) |-> done_o)
        else $error("busy ended without done");
    AST_DONE_PULSE: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    AST_ENC_POS: assert property ($past(rst_b_i) |-> {enc_o.a.pos, enc_o.b.pos, enc_o.z.pos} == $past(enc_i))
        else $error("encoder phase not passed");
    AST_ENC_NEG: assert property ({enc_o.a.neg, enc_o.b.neg, enc_o.z.neg} == ~{enc_o.a.pos, enc_o.b.pos, enc_o.z.pos})
        else $error("encoder pair not inverse");
    cover property (send_i && !busy_o);
    cover property (done_o);
    cover property ($rose(enc_o.z.pos));
endmodule : pos_serial_monitor
bind position_nibble_serial_out pos_serial_monitor u_mon (.clk_i, .rst_b_i, .value_i, .send_i, .busy_o,
    .done_o, .txd_o, .enc_i, .enc_o);
`default_nettype wire

/* verif/host_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_rx_model (
    // line in, decoded character out
    input  wire logic  clk_i,
    input  wire logic  rxd_i,
    output logic [7:0] byte_o,
    output logic       perr_o,
    output logic       valid_o
);
    logic [9:0] sh;
    initial valid_o = 1'b0;
    // sample each bit at its centre, no resync inside a frame
    always
    begin
        @(negedge rxd_i);
        repeat (1302) @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            repeat (2604) @(posedge clk_i);
            sh[i] = rxd_i;
        end
        byte_o = sh[7:0];
        perr_o = (^sh[8:0]) | ~sh[9];
        valid_o = 1'b1;
        @(posedge clk_i);
        valid_o = 1'b0;
    end
endmodule : host_rx_model
`default_nettype wire

/* verif/position_nibble_serial_out_test.sv */
`timescale 1ns/1ns
`default_nettype none
module position_nibble_serial_out_test;
    import pos_serial_pkg::*;
    logic               clk_i = 1'b0;
    logic               rst_b_i = 1'b0;
    logic [VALUE_W-1:0] value_i = '0;
    logic               send_i = 1'b0;
    enc_phase_t         enc_i = '0;
    logic               busy_o, done_o, txd_o, rx_perr, rx_valid;
    enc_diff_t          enc_o;
    logic [7:0]         rx_byte;
    logic [31:0]        seed = 32'h0000_6683;
    logic [31:0]        v;
    int                 n_mismatch = 0;
    int                 num_checks = 0;
    int                 cyc = 0;
    always #20 clk_i = ~clk_i;
    position_nibble_serial_out u_dut (.clk_i, .rst_b_i, .value_i, .send_i, .busy_o, .done_o, .txd_o,
        .enc_i, .enc_o);
    host_rx_model u_rx (.clk_i, .rxd_i(txd_o), .byte_o(rx_byte), .perr_o(rx_perr), .valid_o(rx_valid));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] exp_char(input logic [31:0] val, input int k);
        return {4'(k + 1), val[4*k +: 4]};
    endfunction : exp_char
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // two characters, a reset and one more come to about 83k cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // random phases; positive legs of the pairs must follow one edge later
    always @(posedge clk_i)
    begin
        #1 if (rst_b_i) check("enc", {5'h00, enc_o.a.pos, enc_o.b.pos, enc_o.z.pos}, {5'h00, enc_i});
        #1 enc_i = seed[2:0];
        seed = lfsr(seed);
    end
    // corner value: top nibble all ones, bottom zero; request held while busy
    initial
    begin
        v = {4'hF, seed[27:4], 4'h0};
        repeat (8) @(posedge clk_i);
        #2 rst_b_i = 1'b1;
        value_i = v;
        send_i = 1'b1;
        @(posedge clk_i);
        #2 value_i = ~v;
        check("busy", {7'h00, busy_o}, 8'h01);
        // a whole value is 229k cycles; the run budget covers the low two characters
        for (int k = 0; k < 2; k++)
        begin
            @(posedge rx_valid);
            check("char", rx_byte, exp_char(v, k));
            check("parity", {7'h00, rx_perr}, 8'h00);
        end
        check("busy", {7'h00, busy_o}, 8'h01);
        // mid-run reset inside the stop bit, so the host model stays in step
        @(posedge clk_i);
        #2 rst_b_i = 1'b0;
        #1 v = lfsr(seed) | 32'h0000_000F;
        value_i = v;
        check("busy", {7'h00, busy_o}, 8'h00);
        check("idle", {7'h00, txd_o}, 8'h01);
        @(posedge clk_i);
        #2 rst_b_i = 1'b1;
        @(posedge rx_valid);
        check("char", rx_byte, exp_char(v, 0));
        check("parity", {7'h00, rx_perr}, 8'h00);
        send_i = 1'b0;
        report_and_stop();
    end
endmodule : position_nibble_serial_out_test
`default_nettype wire
